/* File: hw/mtr_range_lookup.sv */
// Memory type range registers with the protected management region.
// Assumes requests and mode inputs come from logic on sys_clk.
`include "mtr_defs.svh"

// What this block does
// - Capability low byte reports the number of variable pairs.
// - Each variable range is a base register plus a mask register.
// - Base register low byte holds the range memory type.
// - Base field sits at bits 12 up; bits 11:8 read as zero.
// - Mask field is 24 bits for 36-bit addresses; upper bits reserved.
// - Hit when address AND mask equals base AND mask.
// - Mask bit 11 is the valid flag; clear means no hit.
// - Writing reserved bits of base or mask raises a fault.
// - Addresses not selected by a broken mask get the default type.
// - Fixed registers map the first megabyte, 8-bit field per subrange.
// - Capability bit 11 advertises the protected region pair.
// - Protected base holds base and type; mask holds valid and mask.
// - Protected pair writes only in management mode, else fault.
// - Protected base: type in bits 7:0, base in bits 31:12.
// - Protected mask in bits 31:12; hit by AND compare.
// - Protected mask bit 11 valid; clear means no effect.
// - Protected pair accessible only once the feature lock enables it.
// - Without the feature, any access to the protected pair faults.
// - In management mode a protected hit uses the protected type.
// - Outside management mode: writes dropped, reads filled, uncacheable.
// - Protected outcome overrides fixed and variable ranges.
// - Only codes 00,01,04,05,06 are legal; others fault on write.
// - Global enable gates all but the protected pair, clear gives uncacheable; fixed enable gates fixed; else default.
// - Fixed first; variable overlaps: same, uncacheable, through over back.
// - Reset clears every valid flag and the global enable.
module mtr_range_lookup
    import mtr_pkg::*;
#(
    parameter bit HAS_PROT = 1'b1
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Model register port
    input wire mtr_req_type req,
    output logic rsp_valid,
    output logic [63:0] rsp_rdata,
    output logic rsp_fault,
    // Core mode
    input wire logic smm_active,
    input wire logic prot_enabled,
    // Lookup
    input wire mtr_acc_type acc,
    output mtr_lkp_type lkp
);

    localparam int VC = 8;
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] def_type_ff;
    logic def_fe_ff;
    logic def_e_ff;
    logic [63:0] fix_ff [0:`MTR_NFIX-1];
    logic [7:0] var_type_ff [0:VC-1];
    logic [`MTR_PA_W-1:12] var_base_ff [0:VC-1];
    logic [`MTR_PA_W-1:12] var_mask_ff [0:VC-1];
    logic [VC-1:0] var_v_ff;
    logic [7:0] prot_type_ff;
    logic [31:12] prot_base_ff;
    logic [31:12] prot_mask_ff;
    logic prot_v_ff;
    logic rsp_valid_ff;
    logic [63:0] rsp_rdata_ff;
    logic rsp_fault_ff;

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    function automatic logic type_ok(input logic [7:0] t);
        type_ok = (t == `MTR_T_UC) || (t == `MTR_T_WC) ||
            (t == `MTR_T_WT) || (t == `MTR_T_WP) ||
            (t == `MTR_T_WB);
    endfunction

    function automatic logic fix_ok(input logic [63:0] d);
        fix_ok = 1'b1;
        for (int b = 0; b < 8; b++)
            fix_ok = fix_ok & type_ok(d[8*b +: 8]);
    endfunction

    function automatic logic rsvd_clean(input logic [63:0] d,
        input logic [63:0] wm);
        rsvd_clean = ((d & ~wm) == 64'h0);
    endfunction

    logic [11:0] fofs;
    logic [11:0] vofs;
    logic in_fix;
    logic in_var;
    logic [2:0] vpair;
    logic nxt_fault;
    logic [63:0] nxt_rdata;
    logic wr_ok;
    assign fofs = req.index - `MTR_IX_FIX_LO;
    assign vofs = req.index - `MTR_IX_VAR_LO;
    assign in_fix = (req.index >= `MTR_IX_FIX_LO) &&
        (req.index < `MTR_IX_FIX_END);
    assign in_var = (req.index >= `MTR_IX_VAR_LO) &&
        (req.index < `MTR_IX_VAR_END);
    assign vpair = vofs[3:1];
    always_comb
    begin
        nxt_fault = 1'b0;
        nxt_rdata = 64'h0;
        if (req.index == `MTR_IX_CAP)
        begin
            nxt_rdata[7:0] = `MTR_VARIABLE_PAIR_COUNT;
            nxt_rdata[`MTR_CAP_FIX_BIT] = 1'b1;
            nxt_rdata[`MTR_CAP_WC_BIT] = 1'b1;
            nxt_rdata[`MTR_CAP_PROT_BIT] = HAS_PROT;
            nxt_fault = req.write; // Capability is read-only
        end
        else if (req.index == `MTR_IX_DEF)
        begin
            nxt_rdata[7:0] = def_type_ff;
            nxt_rdata[`MTR_FE_BIT] = def_fe_ff;
            nxt_rdata[`MTR_E_BIT] = def_e_ff;
            nxt_fault = req.write &&
                (!rsvd_clean(req.wdata, `MTR_DEF_WMASK) ||
                !type_ok(req.wdata[7:0]));
        end
        else if (in_fix)
        begin
            nxt_rdata = fix_ff[fofs[3:0]];
            nxt_fault = req.write && !fix_ok(req.wdata);
        end
        else if (req.index == `MTR_IX_PBASE ||
            req.index == `MTR_IX_PMASK)
        begin
            if (!HAS_PROT || !prot_enabled)
                nxt_fault = 1'b1;
            else if (req.write)
            begin
                nxt_fault = !smm_active;
                if (req.index == `MTR_IX_PBASE)
                    nxt_fault = nxt_fault ||
                        !rsvd_clean(req.wdata, `MTR_PBASE_WMASK) ||
                        !type_ok(req.wdata[7:0]);
                else
                    nxt_fault = nxt_fault ||
                        !rsvd_clean(req.wdata, `MTR_PMASK_WMASK);
            end
            if (req.index == `MTR_IX_PBASE)
            begin
                nxt_rdata[31:12] = prot_base_ff;
                nxt_rdata[7:0] = prot_type_ff;
            end
            else
            begin
                nxt_rdata[31:12] = prot_mask_ff;
                nxt_rdata[`MTR_V_BIT] = prot_v_ff;
            end
        end
        else if (in_var)
        begin
            if (!vofs[0])
            begin
                // Base register: type low, base above bit 12
                nxt_rdata[`MTR_PA_W-1:12] = var_base_ff[vpair];
                nxt_rdata[7:0] = var_type_ff[vpair];
                nxt_fault = req.write &&
                    (!rsvd_clean(req.wdata, `MTR_BASE_WMASK) ||
                    !type_ok(req.wdata[7:0]));
            end
            else
            begin
                nxt_rdata[`MTR_PA_W-1:12] = var_mask_ff[vpair];
                nxt_rdata[`MTR_V_BIT] = var_v_ff[vpair];
                nxt_fault = req.write &&
                    !rsvd_clean(req.wdata, `MTR_MASK_WMASK);
            end
        end
        else
            nxt_fault = 1'b1; // Unimplemented index faults either way
    end

    // A faulting write leaves every register untouched
    assign wr_ok = req.valid && req.write && !nxt_fault;

    // ----------------------------------------
    // Register state and response
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            def_type_ff <= `MTR_T_UC;
            def_fe_ff <= 1'b0;
            def_e_ff <= 1'b0;
        end
        else if (wr_ok && req.index == `MTR_IX_DEF)
        begin
            def_type_ff <= req.wdata[7:0];
            def_fe_ff <= req.wdata[`MTR_FE_BIT];
            def_e_ff <= req.wdata[`MTR_E_BIT];
        end
    end

    // Fixed range registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            for (int i = 0; i < `MTR_NFIX; i++)
                fix_ff[i] <= 64'h0;
        else if (wr_ok && in_fix)
            fix_ff[fofs[3:0]] <= req.wdata;
    end

    // Variable range pairs
    genvar g;
    generate
        for (g = 0; g < VC; g++)
        begin : g_var
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    var_type_ff[g] <= `MTR_T_UC;
                    var_base_ff[g] <= '0;
                    var_mask_ff[g] <= '0;
                    var_v_ff[g] <= 1'b0;
                end
                else if (wr_ok && in_var && vpair == 3'(g))
                begin
                    // Even index is base, odd is mask
                    if (!vofs[0])
                    begin
                        var_type_ff[g] <= req.wdata[7:0];
                        var_base_ff[g] <=
                            req.wdata[`MTR_PA_W-1:12];
                    end
                    else
                    begin
                        var_mask_ff[g] <= req.wdata[`MTR_PA_W-1:12];
                        var_v_ff[g] <= req.wdata[`MTR_V_BIT];
                    end
                end
            end
        end
    endgenerate

    // Protected region pair
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prot_type_ff <= `MTR_T_UC;
            prot_base_ff <= '0;
            prot_mask_ff <= '0;
            prot_v_ff <= 1'b0;
        end
        else if (wr_ok && req.index == `MTR_IX_PBASE)
        begin
            prot_type_ff <= req.wdata[7:0];
            prot_base_ff <= req.wdata[31:12];
        end
        else if (wr_ok && req.index == `MTR_IX_PMASK)
        begin
            prot_mask_ff <= req.wdata[31:12];
            prot_v_ff <= req.wdata[`MTR_V_BIT];
        end
    end

    // Response
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rsp_valid_ff <= 1'b0;
            rsp_rdata_ff <= 64'h0;
            rsp_fault_ff <= 1'b0;
        end
        else
        begin
            rsp_valid_ff <= req.valid;
            rsp_fault_ff <= req.valid && nxt_fault;
            rsp_rdata_ff <= (req.valid && !req.write && !nxt_fault) ?
                nxt_rdata : 64'h0;
        end
    end
    assign rsp_valid = rsp_valid_ff;
    assign rsp_rdata = rsp_rdata_ff;
    assign rsp_fault = rsp_fault_ff;

    // ----------------------------------------
    // Lookup
    // ----------------------------------------
    logic [VC-1:0] vhit;
    logic [7:0] fix_type;
    logic low_mb;
    logic prot_hit;
    logic [7:0] var_type;
    logic [7:0] first_t;
    logic any_hit;
    logic same;
    logic has_uc;
    logic only_wt_wb;
    logic [3:0] fix_reg;
    logic [2:0] fix_fld;
    generate
        for (g = 0; g < VC; g++)
        begin : g_hit
            // A broken mask is used as is: each clear bit widens what matches
            assign vhit[g] = var_v_ff[g] &&
                ((acc.addr[`MTR_PA_W-1:12] & var_mask_ff[g]) ==
                (var_base_ff[g] & var_mask_ff[g]));
        end
    endgenerate

    // Fixed field: 64K steps, then 16K, then 4K
    always_comb
    begin
        if (!acc.addr[19])
        begin
            fix_reg = 4'h0;
            fix_fld = acc.addr[18:16];
        end
        else if (!acc.addr[18])
        begin
            fix_reg = {3'h0, acc.addr[17]} + 4'h1;
            fix_fld = acc.addr[16:14];
        end
        else
        begin
            fix_reg = {1'b0, acc.addr[17:15]} + 4'h3;
            fix_fld = acc.addr[14:12];
        end
    end
    assign fix_type = fix_ff[fix_reg][8*fix_fld +: 8];
    assign low_mb = (acc.addr[`MTR_PA_W-1:`MTR_LOW_MB] == '0);
    assign prot_hit = prot_v_ff &&
        (acc.addr[`MTR_PA_W-1:`MTR_PROT_TOP] == '0) &&
        ((acc.addr[31:12] & prot_mask_ff) ==
        (prot_base_ff & prot_mask_ff));
    always_comb
    begin
        any_hit = 1'b0;
        same = 1'b1;
        first_t = `MTR_T_UC;
        has_uc = 1'b0;
        only_wt_wb = 1'b1;
        for (int i = VC - 1; i >= 0; i--)
            if (vhit[i])
            begin
                first_t = var_type_ff[i];
                any_hit = 1'b1;
            end
        for (int i = 0; i < VC; i++)
            if (vhit[i])
            begin
                same = same && (var_type_ff[i] == first_t);
                has_uc = has_uc || (var_type_ff[i] == `MTR_T_UC);
                only_wt_wb = only_wt_wb && (var_type_ff[i] == `MTR_T_WT ||
                    var_type_ff[i] == `MTR_T_WB);
            end
        if (!any_hit)
            var_type = def_type_ff;
        else if (same)
            var_type = first_t;
        else if (has_uc)
            var_type = `MTR_T_UC;
        else if (only_wt_wb)
            var_type = `MTR_T_WT;
        else
            var_type = `MTR_T_UC; // Undefined overlap: take the safest type
    end

    // Purely combinational so the access path adds no cycle
    always_comb
    begin
        lkp.discard_write = 1'b0;
        lkp.fill_read = 1'b0;
        if (prot_hit && smm_active)
            lkp.mem_type = prot_type_ff;
        else if (prot_hit)
        begin
            lkp.mem_type = `MTR_T_UC;
            lkp.discard_write = acc.write;
            lkp.fill_read = !acc.write;
        end
        else if (!def_e_ff)
            lkp.mem_type = `MTR_T_UC;
        else if (def_fe_ff && low_mb)
            lkp.mem_type = fix_type;
        else
            lkp.mem_type = var_type;
    end

endmodule

/* File: hw/mtr_defs.svh */
// Constants of the memory type range lookup: widths, codes, indices.
// Assumes it is included by bare name from the package and the module.
`ifndef MTR_DEFS_SVH
`define MTR_DEFS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define MTR_PA_W 36
`define MTR_VARIABLE_PAIR_COUNT 8'h08
`define MTR_NFIX 11
`define MTR_LOW_MB 20
`define MTR_PROT_TOP 32

// ----------------------------------------
// Memory type codes
// ----------------------------------------
`define MTR_T_UC 8'h00
`define MTR_T_WC 8'h01
`define MTR_T_WT 8'h04
`define MTR_T_WP 8'h05
`define MTR_T_WB 8'h06
`define MTR_FILL_BYTE 8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MTR_V_BIT 11
`define MTR_E_BIT 11
`define MTR_FE_BIT 10
`define MTR_CAP_FIX_BIT 8
`define MTR_CAP_WC_BIT 10
`define MTR_CAP_PROT_BIT 11

// ----------------------------------------
// Writable bits per register, all others reserved
// ----------------------------------------
`define MTR_BASE_WMASK 64'h0000_000f_ffff_f0ff
`define MTR_MASK_WMASK 64'h0000_000f_ffff_f800
`define MTR_DEF_WMASK 64'h0000_0000_0000_0cff
`define MTR_PBASE_WMASK 64'h0000_0000_ffff_f0ff
`define MTR_PMASK_WMASK 64'h0000_0000_ffff_f800

// ----------------------------------------
// Register indices on the model register port
// ----------------------------------------
`define MTR_IX_CAP 12'h000
`define MTR_IX_DEF 12'h001
`define MTR_IX_FIX_LO 12'h010
`define MTR_IX_FIX_END 12'h01b
`define MTR_IX_PBASE 12'h020
`define MTR_IX_PMASK 12'h021
`define MTR_IX_VAR_LO 12'h100
`define MTR_IX_VAR_END 12'h110

`endif

/* File: hw/mtr_pkg.sv */
// Types shared by the range lookup and whoever connects to it.
// Assumes the constants header sits on the include path.
package mtr_pkg;
`include "mtr_defs.svh"

    // Model register read or write request
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] index;
        logic [63:0] wdata;
    } mtr_req_type;

    // Access presented by the core
    typedef struct packed {
        logic [`MTR_PA_W-1:0] addr;
        logic write;
    } mtr_acc_type;

    // Lookup outcome
    typedef struct packed {
        logic [7:0] mem_type;
        logic discard_write;
        logic fill_read;
    } mtr_lkp_type;
endpackage

/* File: tb/mtr_range_lookup_checker.sv */
// Port-level checker for the memory type range lookup.
// Assumes it is bound to the top module and sees only its ports.
`include "mtr_defs.svh"

module mtr_range_lookup_checker
    import mtr_pkg::*;
#(
    parameter bit HAS_PROT = 1'b1
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire mtr_req_type req,
    input wire logic rsp_valid,
    input wire logic [63:0] rsp_rdata,
    input wire logic rsp_fault,
    // Mode and lookup
    input wire logic smm_active,
    input wire logic prot_enabled,
    input wire mtr_acc_type acc,
    input wire mtr_lkp_type lkp
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic is_prot;
    logic is_vbase;
    assign is_prot = req.index == `MTR_IX_PBASE || req.index == `MTR_IX_PMASK;
    assign is_vbase = req.index[11:4] == 8'h10 && !req.index[0];

    // ----------------------------------------
    // Register port and lookup
    // ----------------------------------------
    a_rsp_one_cycle: assert property (req.valid |=> rsp_valid)
        else $error("no answer one cycle after a request");
    a_rsp_no_spurious: assert property (!req.valid |=> !rsp_valid)
        else $error("answer without a request");
    a_cap_read_value: assert property (req.valid && !req.write &&
        req.index == `MTR_IX_CAP |=> rsp_rdata[7:0] == `MTR_VARIABLE_PAIR_COUNT
        && rsp_rdata[11] == HAS_PROT && !rsp_fault)
        else $error("capability read value wrong");
    a_cap_write_fault: assert property (req.valid && req.write &&
        req.index == `MTR_IX_CAP |=> rsp_fault)
        else $error("capability write did not fault");
    a_resv_base_fault: assert property (req.valid && req.write &&
        is_vbase && (req.wdata & ~`MTR_BASE_WMASK) != 64'h0 |=> rsp_fault)
        else $error("reserved base bits accepted");
    a_bad_type_fault: assert property (req.valid && req.write &&
        is_vbase && !(req.wdata[7:0] inside {8'h00, 8'h01, 8'h04,
        8'h05, 8'h06}) |=> rsp_fault)
        else $error("illegal type code accepted");
    a_prot_write_mode: assert property (req.valid && req.write &&
        is_prot && !smm_active |=> rsp_valid && rsp_fault)
        else $error("protected write outside mode accepted");
    a_prot_gate_off: assert property (req.valid && is_prot &&
        !prot_enabled |=> rsp_fault && rsp_rdata == 64'h0)
        else $error("protected pair reached while not enabled");
    a_fault_no_data: assert property (rsp_fault |-> rsp_rdata == 64'h0)
        else $error("faulting answer carries data");
    a_discard_cond: assert property (lkp.discard_write |-> acc.write &&
        !smm_active && lkp.mem_type == `MTR_T_UC && !lkp.fill_read)
        else $error("write discard in wrong condition");
    a_fill_cond: assert property (lkp.fill_read |-> !acc.write &&
        !smm_active && lkp.mem_type == `MTR_T_UC)
        else $error("read fill in wrong condition");
    a_mode_no_block: assert property (smm_active |->
        !lkp.discard_write && !lkp.fill_read)
        else $error("access blocked inside management mode");

    c_discard: cover property (lkp.discard_write);
    c_fill: cover property (lkp.fill_read);
    c_fault: cover property (rsp_fault);
endmodule

bind mtr_range_lookup mtr_range_lookup_checker #(.HAS_PROT(HAS_PROT)) chk_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .req(req),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .rsp_fault(rsp_fault),
    .smm_active(smm_active),
    .prot_enabled(prot_enabled),
    .acc(acc),
    .lkp(lkp)
);

/* File: tb/mtr_core_model.sv */
// Behavioural core access path: presents one physical address at a time.
// Assumes the bench raises go at a falling edge and drops it one cycle later, before checking.
module mtr_core_model
    import mtr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Command from the bench
    input wire logic go,
    input wire logic [35:0] cmd_addr,
    input wire logic cmd_write,
    // Access to the lookup
    output mtr_acc_type acc
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle cycles toggle every bit so no stale address looks valid
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            acc <= '0;
        else if (go)
            acc <= '{addr: cmd_addr, write: cmd_write};
        else
            acc <= '{addr: ~acc.addr, write: ~acc.write};
    end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the memory type range lookup.
// Assumes the design answers each register request one cycle later.
`include "mtr_defs.svh"

module tb_top;
    import mtr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk;
    logic rst;
    mtr_req_type req;
    logic rsp_valid;
    logic [63:0] rsp_rdata;
    logic rsp_fault;
    logic smm_active;
    logic prot_enabled;
    logic go;
    logic [35:0] cmd_addr;
    logic cmd_write;
    mtr_acc_type acc;
    mtr_lkp_type lkp;
    int miscompares;
    int checked;
    logic [7:0] good [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
    logic [7:0] bad [4] = '{8'h02, 8'h03, 8'h07, 8'hff};

    mtr_range_lookup #(.HAS_PROT(1'b1)) dut_u (
        .sys_clk(sys_clk),
        .rst(rst),
        .req(req),
        .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata),
        .rsp_fault(rsp_fault),
        .smm_active(smm_active),
        .prot_enabled(prot_enabled),
        .acc(acc),
        .lkp(lkp)
    );

    mtr_core_model core_u (
        .sys_clk(sys_clk),
        .rst(rst),
        .go(go),
        .cmd_addr(cmd_addr),
        .cmd_write(cmd_write),
        .acc(acc)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task end_sim;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One request per call; valid drops for a cycle before the next
    task reg_op(input logic w, input logic [11:0] ix, input logic [63:0] wd,
                input logic [63:0] er, input logic ef);
        @(negedge sys_clk);
        req = '{valid: 1'b1, write: w, index: ix, wdata: wd};
        @(negedge sys_clk);
        req.valid = 1'b0;
        chk("rsp_valid", rsp_valid, 1'b1);
        chk("rsp_fault", rsp_fault, ef);
        chk("rsp_rdata", rsp_rdata, er);
    endtask

    task wr(input logic [11:0] ix, input logic [63:0] wd, input logic ef);
        reg_op(1'b1, ix, wd, 64'h0, ef);
    endtask

    task rd(input logic [11:0] ix, input logic [63:0] er, input logic ef);
        reg_op(1'b0, ix, 64'h0, er, ef);
    endtask

    task lk(input logic [35:0] a, input logic w, input logic [7:0] et,
            input logic ed, input logic ef);
        @(negedge sys_clk);
        go = 1'b1;
        cmd_addr = a;
        cmd_write = w;
        @(negedge sys_clk);
        go = 1'b0;
        chk("mem_type", lkp.mem_type, et);
        chk("discard_write", lkp.discard_write, ed);
        chk("fill_read", lkp.fill_read, ef);
    endtask

    // ----------------------------------------
    // Clock, reset and watchdog
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        end_sim();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        req = '0;
        smm_active = 1'b0;
        prot_enabled = 1'b0;
        go = 1'b0;
        cmd_addr = 36'h0;
        cmd_write = 1'b0;
        miscompares = 0;
        checked = 0;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        lk(36'h004001000, 1'b0, `MTR_T_UC, 1'b0, 1'b0);
        rd(12'h101, 64'h0, 1'b0);
        rd(`MTR_IX_CAP, 64'h0d08, 1'b0);
        wr(`MTR_IX_CAP, 64'h0, 1'b1);
        rd(12'h050, 64'h0, 1'b1);
        wr(`MTR_IX_DEF, 64'hc05, 1'b0);
        rd(`MTR_IX_DEF, 64'hc05, 1'b0);
        foreach (bad[i])
            wr(`MTR_IX_DEF, {56'h0c, bad[i]}, 1'b1);
        foreach (good[i])
        begin
            wr(12'h100, {56'h0, good[i]}, 1'b0);
            rd(12'h100, {56'h0, good[i]}, 1'b0);
        end
        // Variable pairs: invalid first, then enabled and overlapped
        wr(12'h100, 64'h004000006, 1'b0);
        wr(12'h101, 64'hffc000000, 1'b0);
        lk(36'h004001000, 1'b0, `MTR_T_WP, 1'b0, 1'b0);
        wr(12'h101, 64'hffc000800, 1'b0);
        lk(36'h004001000, 1'b0, `MTR_T_WB, 1'b0, 1'b0);
        lk(36'h008000000, 1'b0, `MTR_T_WP, 1'b0, 1'b0);
        wr(12'h100, 64'h1004000006, 1'b1);
        wr(12'h101, 64'hffc000801, 1'b1);
        wr(12'h101, 64'h1ffc000800, 1'b1);
        rd(12'h100, 64'h004000006, 1'b0);
        wr(12'h102, 64'h004000000, 1'b0);
        wr(12'h103, 64'hfffc00800, 1'b0);
        lk(36'h004001000, 1'b0, `MTR_T_UC, 1'b0, 1'b0);
        lk(36'h004800000, 1'b0, `MTR_T_WB, 1'b0, 1'b0);
        wr(12'h102, 64'h004000004, 1'b0);
        lk(36'h004001000, 1'b0, `MTR_T_WT, 1'b0, 1'b0);
        // A mask with a hole at bit 20 selects two separate blocks
        wr(12'h104, 64'h020000001, 1'b0);
        wr(12'h105, 64'hfffeff800, 1'b0);
        lk(36'h020100000, 1'b0, `MTR_T_WC, 1'b0, 1'b0);
        lk(36'h020001000, 1'b0, `MTR_T_WP, 1'b0, 1'b0);
        // Fixed ranges in the first megabyte
        wr(12'h010, 64'h0400, 1'b0);
        wr(12'h01a, 64'h0100000000000000, 1'b0);
        lk(36'h000010000, 1'b0, `MTR_T_WT, 1'b0, 1'b0);
        lk(36'h000000000, 1'b0, `MTR_T_UC, 1'b0, 1'b0);
        lk(36'h0000ff000, 1'b0, `MTR_T_WC, 1'b0, 1'b0);
        wr(`MTR_IX_DEF, 64'h805, 1'b0);
        lk(36'h000010000, 1'b0, `MTR_T_WP, 1'b0, 1'b0);
        wr(`MTR_IX_DEF, 64'h005, 1'b0);
        lk(36'h004800000, 1'b0, `MTR_T_UC, 1'b0, 1'b0);
        wr(`MTR_IX_DEF, 64'hc05, 1'b0);
        // Protected region over the top fixed page
        rd(`MTR_IX_PBASE, 64'h0, 1'b1);
        @(negedge sys_clk);
        prot_enabled = 1'b1;
        wr(`MTR_IX_PBASE, 64'hff006, 1'b1);
        @(negedge sys_clk);
        smm_active = 1'b1;
        wr(`MTR_IX_PBASE, 64'hff106, 1'b1);
        wr(`MTR_IX_PBASE, 64'hff006, 1'b0);
        wr(`MTR_IX_PMASK, 64'hfffff800, 1'b0);
        lk(36'h0000ff000, 1'b1, `MTR_T_WB, 1'b0, 1'b0);
        @(negedge sys_clk);
        smm_active = 1'b0;
        rd(`MTR_IX_PBASE, 64'hff006, 1'b0);
        lk(36'h0000ff000, 1'b0, `MTR_T_UC, 1'b0, 1'b1);
        lk(36'h0000ff000, 1'b1, `MTR_T_UC, 1'b1, 1'b0);
        lk(36'h0000fe000, 1'b0, `MTR_T_UC, 1'b0, 1'b0);
        @(negedge sys_clk);
        smm_active = 1'b1;
        wr(`MTR_IX_PMASK, 64'hfffff000, 1'b0);
        @(negedge sys_clk);
        smm_active = 1'b0;
        lk(36'h0000ff000, 1'b0, `MTR_T_WC, 1'b0, 1'b0);
        end_sim();
    end
endmodule
